// file: cog_pkg.sv
package cog_pkg;
  // Word offsets on the Wishbone bus
  localparam logic [7:0] OFS_FALL_ENABLE = 8'h00;
  localparam logic [7:0] OFS_FALL_MODE = 8'h04;
  localparam logic [7:0] OFS_SHUTDOWN_CTRL = 8'h08;
  localparam logic [7:0] OFS_SHUTDOWN_SRC = 8'h0c;
  localparam logic [7:0] OFS_STEERING = 8'h10;
  localparam logic [7:0] OFS_RISE_DB = 8'h14;
  localparam logic [7:0] OFS_GEN_CTRL = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h24;
  // Field positions
  localparam int SD_ACTIVE_BIT = 7;
  localparam int SD_RESTART_BIT = 6;
  localparam int SD_BD_LSB = 4;
  localparam int SD_AC_LSB = 2;
  localparam int GEN_POL_LSB = 0;
  localparam int GEN_RDBS_BIT = 4;
  // Implemented-bit masks
  localparam logic [7:0] MASK_FALL = 8'h7f;
  localparam logic [7:0] MASK_SD_CTRL = 8'h7c;
  localparam logic [7:0] MASK_SD_SRC = 8'h0f;
  localparam logic [7:0] MASK_DB = 8'h3f;
  localparam logic [7:0] MASK_GEN = 8'h1f;
  localparam logic [7:0] MASK_IRQ = 8'h07;
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_DB = 8'h00;
  // Irq bits
  localparam int IRQ_SD_ENTER = 0;
  localparam int IRQ_SD_EXIT = 1;
  localparam int IRQ_FALL = 2;
  // Override select codes
  localparam logic [1:0] OVR_INACTIVE = 2'b00;
  localparam logic [1:0] OVR_TRISTATE = 2'b01;
  localparam logic [1:0] OVR_LOW = 2'b10;
  localparam logic [1:0] OVR_HIGH = 2'b11;
  typedef enum logic [1:0] {
    DB_IDLE = 2'b00,
    DB_COUNT = 2'b01
  } db_state_e;
endpackage

// file: cog_shutdown_steer.sv
// Overview of operation
// - Mode one: falling edge, after phase delay
// - Mode zero: low level gives immediate fall
// - Disabled falling source is ignored
// - Fall bits 0-6: pin,cmp1,cmp2,lc1,cc1,cc2,pulse_width_unit_3
// - Status bit set while in shutdown
// - Auto-restart enable bit in shutdown control
// - B/D override: high, low, tristate, inactive
// - A/C override: high, low, tristate, inactive
// - Enabled shutdown source low forces shutdown
// - Static data bits D,C,B,A at 7..4
// - Steer one passes waveform, zero static
// - Select zero: dead-band in clock periods
// - Select one: dead-band in chain elements
// - Unimplemented bits read as zero
// - Control resets zero, dead-band count kept
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
module cog_shutdown_steer
  import cog_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic por,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Event sources
  input wire logic remapped_input_pin,
  input wire logic cmp1_out,
  input wire logic cmp2_out,
  input wire logic logic_cell_1,
  input wire logic logic_cell_2,
  input wire logic capture_compare_1,
  input wire logic capture_compare_2,
  input wire logic pulse_width_unit_3,
  // Link to rest of generator
  input wire logic rise_event,
  input wire logic fall_phase_done,
  input wire logic delay_chain_tick,
  input wire logic [3:0] waveform_in,
  output logic fall_event_now,
  output logic fall_edge_req,
  output logic primary_go,
  // Power switch outputs and interrupt
  output logic [3:0] out_level,
  output logic [3:0] out_oe_n,
  output logic irq
);
  logic [6:0] fall_enable_r;
  logic [6:0] fall_edge_mode_bits_r;
  logic auto_restart_enable_r;
  logic [1:0] override_level_bd_r;
  logic [1:0] override_level_ac_r;
  logic [3:0] sd_src_enable_r;
  logic [3:0] static_level_r;
  logic [3:0] steer_r;
  logic [5:0] rise_deadband_count_r;
  logic rise_deadband_source_sel_r;
  logic [3:0] polarity_r;
  logic shutdown_active_flag_r;
  logic [2:0] irq_status_r;
  logic [2:0] irq_enable_r;
  logic [6:0] fall_src_prev_r;
  logic [5:0] db_cnt_r;
  db_state_e db_state_r;
  logic [6:0] fall_src;
  logic [6:0] fall_edge_hits;
  logic [6:0] fall_level_hits;
  logic sd_request;
  logic wb_req;
  logic wb_wr;
  logic db_tick;
  logic [7:0] rd_nxt;
  logic [3:0] out_level_nxt;
  logic [3:0] out_oe_n_nxt;

  assign fall_src = {pulse_width_unit_3, capture_compare_2, capture_compare_1,
                     logic_cell_1, cmp2_out, cmp1_out, remapped_input_pin};
  assign fall_edge_hits = fall_enable_r & fall_edge_mode_bits_r
                          & fall_src_prev_r & ~fall_src;
  assign fall_level_hits = fall_enable_r & ~fall_edge_mode_bits_r & ~fall_src;
  assign sd_request = |(sd_src_enable_r & ~{logic_cell_2, cmp2_out, cmp1_out,
                                            remapped_input_pin});
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Write lands on the edge that sees ack, as the master expects
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign db_tick = rise_deadband_source_sel_r ? delay_chain_tick : 1'b1;

  // Edge history for falling-edge detection
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fall_src_prev_r <= 7'h00;
    end else begin
      fall_src_prev_r <= fall_src;
    end
  end

  // Registered event outputs to the phase-delay logic
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fall_event_now <= 1'b0;
      fall_edge_req <= 1'b0;
    end else begin
      fall_event_now <= |fall_level_hits;
      fall_edge_req <= |fall_edge_hits;
    end
  end

  // Control registers, cleared on rst; por alone leaves them
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fall_enable_r <= RST_CTRL[6:0];
      fall_edge_mode_bits_r <= RST_CTRL[6:0];
      auto_restart_enable_r <= 1'b0;
      override_level_bd_r <= 2'b00;
      override_level_ac_r <= 2'b00;
      sd_src_enable_r <= RST_CTRL[3:0];
      static_level_r <= RST_CTRL[3:0];
      steer_r <= RST_CTRL[3:0];
      polarity_r <= RST_CTRL[3:0];
      rise_deadband_source_sel_r <= 1'b0;
      irq_enable_r <= RST_CTRL[2:0];
    end else if (wb_wr) begin
      case (wb_adr_i)
        OFS_FALL_ENABLE: fall_enable_r <= wb_dat_i[6:0];
        OFS_FALL_MODE: fall_edge_mode_bits_r <= wb_dat_i[6:0];
        OFS_SHUTDOWN_CTRL: begin
          auto_restart_enable_r <= wb_dat_i[SD_RESTART_BIT];
          override_level_bd_r <= wb_dat_i[SD_BD_LSB +: 2];
          override_level_ac_r <= wb_dat_i[SD_AC_LSB +: 2];
        end
        OFS_SHUTDOWN_SRC: sd_src_enable_r <= wb_dat_i[3:0];
        OFS_STEERING: begin
          static_level_r <= wb_dat_i[7:4];
          steer_r <= wb_dat_i[3:0];
        end
        OFS_GEN_CTRL: begin
          polarity_r <= wb_dat_i[GEN_POL_LSB +: 4];
          rise_deadband_source_sel_r <= wb_dat_i[GEN_RDBS_BIT];
        end
        OFS_IRQ_ENABLE: irq_enable_r <= wb_dat_i[2:0];
        default: ;
      endcase
    end
  end

  // Dead-band count survives resets other than power-on
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      rise_deadband_count_r <= RST_DB[5:0];
    end else if (wb_wr && wb_adr_i == OFS_RISE_DB) begin
      rise_deadband_count_r <= wb_dat_i[5:0];
    end
  end

  // Shutdown state; with restart off, software clears it only by a write in a rise_event cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shutdown_active_flag_r <= 1'b0;
    end else if (sd_request) begin
      shutdown_active_flag_r <= 1'b1;
    end else if (auto_restart_enable_r && rise_event) begin
      shutdown_active_flag_r <= 1'b0;
    end else if (wb_wr && wb_adr_i == OFS_SHUTDOWN_CTRL && !wb_dat_i[SD_ACTIVE_BIT]
                 && rise_event) begin
      shutdown_active_flag_r <= 1'b0;
    end
  end

  // Rising dead-band delay of the primary output
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      db_state_r <= DB_IDLE;
      db_cnt_r <= 6'h00;
      primary_go <= 1'b0;
    end else begin
      primary_go <= 1'b0;
      case (db_state_r)
        DB_IDLE: begin
          if (rise_event) begin
            if (rise_deadband_count_r == 6'h00) begin
              primary_go <= 1'b1;
            end else begin
              db_cnt_r <= rise_deadband_count_r;
              db_state_r <= DB_COUNT;
            end
          end
        end
        DB_COUNT: begin
          if (db_tick) begin
            if (db_cnt_r == 6'h01) begin
              primary_go <= 1'b1;
              db_state_r <= DB_IDLE;
            end
            db_cnt_r <= db_cnt_r - 6'h01;
          end
        end
        default: db_state_r <= DB_IDLE;
      endcase
    end
  end

  // Steering then shutdown override, per output
  always_comb begin
    out_level_nxt = 4'h0;
    out_oe_n_nxt = 4'h0;
    for (int i = 0; i < 4; i++) begin
      logic [1:0] sel;
      sel = (i % 2 == 0) ? override_level_ac_r : override_level_bd_r;
      out_level_nxt[i] = steer_r[i] ? (waveform_in[i] ^ polarity_r[i])
                                    : static_level_r[i];
      if (shutdown_active_flag_r) begin
        case (sel)
          OVR_HIGH: out_level_nxt[i] = 1'b1;
          OVR_LOW: out_level_nxt[i] = 1'b0;
          OVR_TRISTATE: out_oe_n_nxt[i] = 1'b1;
          default: out_level_nxt[i] = polarity_r[i];
        endcase
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_level <= 4'h0;
      out_oe_n <= 4'h0;
    end else begin
      out_level <= out_level_nxt;
      out_oe_n <= out_oe_n_nxt;
    end
  end

  // Sticky interrupt status: set wins over clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_status_r <= 3'h0;
      irq <= 1'b0;
    end else begin
      logic [2:0] clr;
      logic [2:0] set;
      logic [2:0] st;
      clr = (wb_wr && wb_adr_i == OFS_IRQ_CLEAR) ? wb_dat_i[2:0] : 3'h0;
      set = 3'h0;
      set[IRQ_SD_ENTER] = sd_request & ~shutdown_active_flag_r;
      set[IRQ_SD_EXIT] = shutdown_active_flag_r & ~sd_request & rise_event
                         & auto_restart_enable_r;
      set[IRQ_FALL] = |(fall_edge_hits | fall_level_hits);
      st = (irq_status_r & ~clr) | set;
      irq_status_r <= st;
      irq <= |(st & irq_enable_r);
    end
  end

  // Read mux: unimplemented bits read zero
  always_comb begin
    case (wb_adr_i)
      OFS_FALL_ENABLE: rd_nxt = {1'b0, fall_enable_r};
      OFS_FALL_MODE: rd_nxt = {1'b0, fall_edge_mode_bits_r};
      OFS_SHUTDOWN_CTRL: rd_nxt = {shutdown_active_flag_r, auto_restart_enable_r,
                                   override_level_bd_r, override_level_ac_r, 2'b00};
      OFS_SHUTDOWN_SRC: rd_nxt = {4'h0, sd_src_enable_r};
      OFS_STEERING: rd_nxt = {static_level_r, steer_r};
      OFS_RISE_DB: rd_nxt = {2'b00, rise_deadband_count_r};
      OFS_GEN_CTRL: rd_nxt = {3'b000, rise_deadband_source_sel_r, polarity_r};
      OFS_IRQ_STATUS: rd_nxt = {5'h00, irq_status_r};
      OFS_IRQ_ENABLE: rd_nxt = {5'h00, irq_enable_r};
      default: rd_nxt = 8'h00;
    endcase
  end

  // One-wait-state slave, ack drops the cycle after
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? {24'h0, rd_nxt} : 32'h0;
    end
  end
endmodule

// file: cog_shutdown_steer_properties.sv
`timescale 1ns/100ps
module cog_shutdown_steer_properties
  import cog_pkg::*;
(
  // Clock, reset and bus
  input wire logic mclk, rst, por, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  // Sources and results
  input wire logic remapped_input_pin, cmp1_out, cmp2_out, logic_cell_1, logic_cell_2,
  input wire logic capture_compare_1, capture_compare_2, pulse_width_unit_3,
  input wire logic rise_event, fall_event_now, fall_edge_req, primary_go,
  input wire logic [3:0] out_level, out_oe_n
);
  logic [7:0] m_r [0:4];
  logic [5:0] db_r;
  logic rdbs_r;
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
  wire [6:0] fsrc = {pulse_width_unit_3, capture_compare_2, capture_compare_1, logic_cell_1,
    cmp2_out, cmp1_out, remapped_input_pin};
  wire sd_low = |(m_r[3][3:0] & ~{logic_cell_2, cmp2_out, cmp1_out, remapped_input_pin});
  wire [1:0] ac = m_r[2][3:2];
  wire [1:0] bd = m_r[2][5:4];
  // Bus-side copies only; aligned offsets assumed
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 5; i++) m_r[i] <= 8'h00;
      rdbs_r <= 1'b0;
    end else if (wr && wb_adr_i < OFS_RISE_DB) begin
      m_r[wb_adr_i[4:2]] <= wb_dat_i[7:0];
    end else if (wr && wb_adr_i == OFS_GEN_CTRL) begin
      rdbs_r <= wb_dat_i[GEN_RDBS_BIT];
    end
  end
  // Dead-band survives a plain reset
  always_ff @(posedge mclk or posedge por) begin
    if (por) begin
      db_r <= 6'h00;
    end else if (wr && wb_adr_i == OFS_RISE_DB) begin
      db_r <= wb_dat_i[5:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence sd_held;
    sd_low ##1 sd_low;
  endsequence
  bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer late");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  unimpl_zero_a: assert property (wb_ack_o && !$past(wb_we_i) |->
    !(($past(wb_adr_i) == OFS_SHUTDOWN_SRC && wb_dat_o[7:4] != 4'h0)
    || ($past(wb_adr_i) == OFS_SHUTDOWN_CTRL && wb_dat_o[1:0] != 2'h0)
    || ($past(wb_adr_i) <= OFS_FALL_MODE && wb_dat_o[7])))
    else $error("unimplemented bit read as one");
  fall_level_a: assert property (fall_event_now == $past(|(m_r[0][6:0] & ~m_r[1][6:0] & ~fsrc)))
    else $error("level fall wrong");
  fall_edge_a: assert property (fall_edge_req |-> $past(|(m_r[0][6:0] & m_r[1][6:0] & ~fsrc)))
    else $error("edge fall without cause");
  sd_float_a: assert property (sd_held |=> out_oe_n == {bd == OVR_TRISTATE, ac == OVR_TRISTATE,
    bd == OVR_TRISTATE, ac == OVR_TRISTATE})
    else $error("shutdown enables wrong");
  sd_level_a: assert property (sd_held |=> (!ac[1] || out_level[0] == ac[0])
    && (!bd[1] || out_level[1] == bd[0]))
    else $error("shutdown level wrong");
  rise_zero_a: assert property (rise_event && db_r == 6'h00 && !rdbs_r |=> primary_go)
    else $error("zero dead-band late");
endmodule

// file: power_stage_model.sv
`timescale 1ns/100ps
module power_stage_model (
  // Generator side
  input wire logic mclk,
  input wire logic [3:0] out_level,
  input wire logic [3:0] out_oe_n,
  // Switch gates
  output logic [3:0] gate
);
  logic [3:0] last_r = 4'h0;
  // No pull on a gate: a floated one shows the opposite of its last drive
  always_ff @(posedge mclk) begin
    last_r <= (out_level & ~out_oe_n) | (last_r & out_oe_n);
  end
  assign gate = (out_level & ~out_oe_n) | (~last_r & out_oe_n);
endmodule

// file: complementary_output_shutdown_steer_tb.sv
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module complementary_output_shutdown_steer_tb
  import cog_pkg::*;
;
  logic mclk = 0, rst = 1, por = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic rise_event = 0, fall_phase_done = 0, delay_chain_tick = 0, tick_on = 0;
  logic [7:0] wb_adr_i = 8'h00, src = 8'hff;
  logic [3:0] wb_sel_i = 4'h0, waveform_in = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, fall_event_now, fall_edge_req, primary_go, irq;
  wire [3:0] out_level, out_oe_n, gate;
  int fail_count = 0, compares = 0, tc = 0;
  cog_shutdown_steer uut (.mclk, .rst, .por, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .remapped_input_pin(src[0]), .cmp1_out(src[1]),
    .cmp2_out(src[2]), .logic_cell_1(src[3]), .capture_compare_1(src[4]),
    .capture_compare_2(src[5]), .pulse_width_unit_3(src[6]), .logic_cell_2(src[7]),
    .rise_event, .fall_phase_done, .delay_chain_tick, .waveform_in, .fall_event_now,
    .fall_edge_req, .primary_go, .out_level, .out_oe_n, .irq);
  power_stage_model stage (.mclk, .out_level, .out_oe_n, .gate);
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // Slow chain tick, one pulse every third clock
  always @(posedge mclk) begin
    tc <= (tc + 1) % 3;
    delay_chain_tick <= tick_on && tc == 0;
  end
  task automatic close_out;
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    int n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      close_out;
    end
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_sel_i <= 4'h0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic do_reset(input logic p);
    rst <= 1'b1;
    por <= p;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic pulse_rise;
    rise_event <= 1'b1;
    @(posedge mclk);
    rise_event <= 1'b0;
  endtask
  task automatic sd_flag(input logic e);
    logic [7:0] q;
    wb(1'b0, OFS_SHUTDOWN_CTRL, 8'h00, q);
    `CHK(q[SD_ACTIVE_BIT], e)
  endtask
  task automatic t_regs;
    logic [7:0] q;
    logic [7:0] mask [6] = '{8'h7f, 8'h7f, 8'h7c, 8'h0f, 8'hff, 8'h3f};
    for (int i = 0; i < 7; i++) begin
      wr(8'(i * 4), i == 2 ? 8'h7f : 8'hff);
      wb(1'b0, 8'(i * 4), 8'h00, q);
      `CHK(q, i == 6 ? MASK_GEN : mask[i])
    end
    wb(1'b0, 8'h28, 8'h00, q);
    `CHK(q, 8'h00)
    do_reset(1'b0);
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 8'(i * 4), 8'h00, q);
      `CHK(q, i == 5 ? 8'h3f : 8'h00)
    end
  endtask
  task automatic t_steer;
    wr(OFS_STEERING, 8'ha5);
    repeat (3) @(posedge mclk);
    `CHK(gate, 4'b1010)
    wr(OFS_GEN_CTRL, 8'h05);
    waveform_in <= 4'b0100;
    repeat (3) @(posedge mclk);
    `CHK(out_level, 4'b1011)
  endtask
  task automatic t_shut;
    int map [4] = '{0, 1, 2, 7};
    logic [1:0] code;
    wr(OFS_IRQ_ENABLE, 8'h01);
    wr(OFS_SHUTDOWN_SRC, 8'h0f);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_SHUTDOWN_CTRL, 8'(8'h40 | c << 4 | (3 - c) << 2));
      src[map[c]] <= 1'b0;
      repeat (3) @(posedge mclk);
      for (int i = 0; i < 4; i++) begin
        code = i % 2 ? 2'(c) : 2'(3 - c);
        `CHK(out_oe_n[i], code == OVR_TRISTATE)
        if (code != OVR_TRISTATE) `CHK(out_level[i], code[1] ? code[0] : i % 2 == 0)
      end
      sd_flag(1'b1);
      src <= 8'hff;
      @(posedge mclk);
      pulse_rise;
      repeat (3) @(posedge mclk);
      sd_flag(1'b0);
    end
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_ENABLE, 8'h00);
    @(posedge mclk);
    `CHK(irq, 1'b0)
    wr(OFS_IRQ_ENABLE, 8'h01);
    wr(OFS_IRQ_CLEAR, 8'h01);
    @(posedge mclk);
    `CHK(irq, 1'b0)
    wr(OFS_SHUTDOWN_SRC, 8'h0e);
    src[0] <= 1'b0;
    repeat (3) @(posedge mclk);
    sd_flag(1'b0);
    wr(OFS_SHUTDOWN_CTRL, 8'h00);
    src[1] <= 1'b0;
    repeat (3) @(posedge mclk);
    src <= 8'hff;
    pulse_rise;
    repeat (3) @(posedge mclk);
    sd_flag(1'b1);
    do_reset(1'b0);
  endtask
  task automatic t_fall;
    int hits;
    for (int i = 0; i < 7; i++) begin
      wr(OFS_FALL_MODE, 8'h00);
      src[i] <= 1'b0;
      repeat (2) @(posedge mclk);
      `CHK(fall_event_now, 1'b0)
      wr(OFS_FALL_ENABLE, 8'(1 << i));
      @(posedge mclk);
      `CHK(fall_event_now, 1'b1)
      src[i] <= 1'b1;
      wr(OFS_FALL_MODE, 8'(1 << i));
      src[i] <= 1'b0;
      hits = 0;
      repeat (4) begin
        @(posedge mclk);
        if (fall_edge_req === 1'b1) hits++;
      end
      `CHK(hits == 1, 1'b1)
      src[i] <= 1'b1;
      wr(OFS_FALL_ENABLE, 8'h00);
    end
  endtask
  task automatic measure(output int d);
    pulse_rise;
    d = 0;
    while (primary_go !== 1'b1 && d < 40) begin
      @(posedge mclk);
      d++;
    end
  endtask
  task automatic t_rise;
    int d0, d4;
    wr(OFS_RISE_DB, 8'h00);
    measure(d0);
    wr(OFS_RISE_DB, 8'h04);
    measure(d4);
    `CHK(d4 - d0 == 4, 1'b1)
    wr(OFS_GEN_CTRL, 8'h10);
    measure(d4);
    `CHK(d4 == 40, 1'b1)
    tick_on <= 1'b1;
    repeat (20) @(posedge mclk);
    measure(d4);
    `CHK(d4 > 9 && d4 < 16, 1'b1)
  endtask
  initial begin
    do_reset(1'b1);
    t_regs;
    t_steer;
    t_shut;
    t_fall;
    t_rise;
    close_out;
  end
endmodule
bind cog_shutdown_steer cog_shutdown_steer_properties chk (.mclk, .rst, .por, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .remapped_input_pin, .cmp1_out, .cmp2_out, .logic_cell_1, .logic_cell_2, .capture_compare_1,
  .capture_compare_2, .pulse_width_unit_3, .rise_event, .fall_event_now, .fall_edge_req,
  .primary_go, .out_level, .out_oe_n);
